// file: hdl/ccrfs_core.sv
// core programmer state: data-space registers, program counter,
// context flag pairs and the return stack control
// assumes the decoder raises at most one program counter source a cycle
// Notes on behaviour
// [RQ1] accumulator is data-space location FFh
// [RQ2] two pointer registers at 80h and 81h
// [RQ3] two short-direct registers at 82h and 83h
// [RQ4] program counter is twelve bits wide
// [RQ5] program counter increments after each fetch
// [RQ6] relative branch adds signed offset to counter
// [RQ7] jump, call, vector or pop loads counter
// [RQ8] three carry/zero pairs, one per context
// [RQ9] entry switches pairs, interrupt return restores previous
// [RQ10] context switches never alter any flag pair
// [RQ11] only the active context pair is touched
// [RQ12] carry from arithmetic, bit test, rotate left
// [RQ13] zero set when last result is zero
// [RQ14] reset enters non-maskable interrupt context
// [RQ15] six twelve-bit levels, no visible pointer
// [RQ16] call or interrupt pushes counter, oldest dropped
// [RQ17] returns pop first level into the counter
// [RQ18] deep nesting saturates, oldest address lost silently
// [RQ19] return on empty stack continues straight on
// [RQ20] only the program counter is stacked
// [RQ21] reset clears stack, counter to vector 0FFEh
// [RQ22] alu writes flags with its result
`timescale 1ns/1ps
`default_nettype none
module ccrfs_core
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_data_addr,
	input wire logic i_data_rd,
	input wire logic i_data_wr,
	input wire logic [7:0] i_data_wdata,
	input wire logic i_fetch,
	input wire logic i_branch_rel,
	input wire logic [7:0] i_rel_offset,
	input wire logic i_absolute_branch,
	input wire logic i_call,
	input wire logic [11:0] i_target,
	input wire logic i_irq_entry,
	input wire logic i_nmi_entry,
	input wire logic [11:0] i_vector,
	input wire logic i_subroutine_return,
	input wire logic i_return_from_interrupt,
	input wire logic i_alu_valid,
	input wire logic i_alu_carry_en,
	input wire logic [7:0] i_alu_result,
	input wire logic i_alu_carry,
	input wire logic i_rotate_left,
	input wire logic i_bit_test,
	input wire logic i_bit_value,
	output logic [7:0] o_data_rdata,
	output logic o_data_hit,
	output logic [11:0] o_program_counter,
	output logic [7:0] o_accumulator,
	output logic o_carry,
	output logic o_zero,
	output logic [2:0] o_context
);
	logic [ccrfs_pkg::PC_W-1:0] pc_r;
	logic [ccrfs_pkg::PC_W-1:0] pc_nxt;
	ccrfs_pkg::ccrfs_ctx_type ctx_r;
	ccrfs_pkg::ccrfs_ctx_type ctx_nxt;
	ccrfs_pkg::ccrfs_ctx_type hist0_r;
	ccrfs_pkg::ccrfs_ctx_type hist0_nxt;
	ccrfs_pkg::ccrfs_ctx_type hist1_r;
	ccrfs_pkg::ccrfs_ctx_type hist1_nxt;
	logic [2:0] carry_r;
	logic [2:0] carry_nxt;
	logic [2:0] zero_r;
	logic [2:0] zero_nxt;
	logic [ccrfs_pkg::NUM_REGS-1:0][7:0] regs_r;
	logic [ccrfs_pkg::NUM_REGS-1:0][7:0] regs_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic hit_r;
	logic hit_nxt;
	logic carry_out_r;
	logic carry_out_nxt;
	logic zero_out_r;
	logic zero_out_nxt;
	logic [1:0] cur;
	logic [3:0] wr_dec;
	logic [3:0] rd_dec;
	logic [7:0] rot_val;
	logic entry;

	ccrfs_stack_if stk();

	ccrfs_stack u_stack
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.st(stk.store)
	);

	// {hit, index}; unmapped addresses give hit low
	function automatic logic [3:0] decode(input logic [7:0] addr);
		case (addr)
			ccrfs_pkg::ADDR_PTR_FIRST: decode = {1'b1, ccrfs_pkg::IDX_PTR_FIRST}; // [RQ2]
			ccrfs_pkg::ADDR_PTR_SECOND: decode = {1'b1, ccrfs_pkg::IDX_PTR_SECOND}; // [RQ2]
			ccrfs_pkg::ADDR_SHORT_FIRST: decode = {1'b1, ccrfs_pkg::IDX_SHORT_FIRST}; // [RQ3]
			ccrfs_pkg::ADDR_SHORT_SECOND: decode = {1'b1, ccrfs_pkg::IDX_SHORT_SECOND}; // [RQ3]
			ccrfs_pkg::ADDR_ACCUMULATOR: decode = {1'b1, ccrfs_pkg::IDX_ACC}; // [RQ1]
			default: decode = 4'h0;
		endcase
	endfunction

	function automatic logic [1:0] pair_of(input ccrfs_pkg::ccrfs_ctx_type c);
		case (c)
			ccrfs_pkg::CTX_NORMAL: pair_of = ccrfs_pkg::PAIR_NORMAL;
			ccrfs_pkg::CTX_IRQ: pair_of = ccrfs_pkg::PAIR_IRQ;
			default: pair_of = ccrfs_pkg::PAIR_NMI;
		endcase
	endfunction

	assign entry = i_irq_entry | i_nmi_entry;

	always_comb
	begin
		cur = pair_of(ctx_r);
		wr_dec = decode(i_data_addr);
		rd_dec = decode(i_data_addr);
		rot_val = {regs_r[ccrfs_pkg::IDX_ACC][6:0], carry_r[cur]};
		pc_nxt = pc_r;
		ctx_nxt = ctx_r;
		hist0_nxt = hist0_r;
		hist1_nxt = hist1_r;
		carry_nxt = carry_r;
		zero_nxt = zero_r;
		regs_nxt = regs_r;
		rdata_nxt = 8'h00;
		hit_nxt = 1'b0;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		// only the counter is stacked; data registers stay with software
		stk.push_data = pc_r; // [RQ20]
		// program counter sources in priority order
		if (entry)
		begin
			stk.push = 1'b1; // [RQ16]
			pc_nxt = i_vector; // [RQ7]
			ctx_nxt = i_nmi_entry ? ccrfs_pkg::CTX_NMI : ccrfs_pkg::CTX_IRQ; // [RQ9]
			hist0_nxt = ctx_r;
			hist1_nxt = hist0_r;
		end
		else if (i_call)
		begin
			stk.push = 1'b1; // [RQ16]
			pc_nxt = i_target; // [RQ7]
		end
		else if (i_absolute_branch)
			pc_nxt = i_target; // [RQ7]
		else if (i_subroutine_return || i_return_from_interrupt)
		begin
			stk.pop = 1'b1; // [RQ17]
			// an empty stack has nothing to give, so the next instruction runs
			if (!stk.empty)
				pc_nxt = stk.top; // [RQ7] [RQ19]
			if (i_return_from_interrupt)
			begin
				ctx_nxt = hist0_r; // [RQ9]
				hist0_nxt = hist1_r;
				hist1_nxt = ccrfs_pkg::CTX_NORMAL;
			end
		end
		else if (i_branch_rel)
			pc_nxt = pc_r + {{4{i_rel_offset[7]}}, i_rel_offset}; // [RQ6]
		else if (i_fetch)
			pc_nxt = pc_r + 12'h001; // [RQ5] [RQ4]
		// flags: only the active pair, never touched by a switch itself
		if (i_alu_valid)
		begin
			regs_nxt[ccrfs_pkg::IDX_ACC] = i_alu_result; // [RQ22]
			if (i_alu_carry_en)
				carry_nxt[cur] = i_alu_carry; // [RQ12] [RQ11]
			zero_nxt[cur] = (i_alu_result == 8'h00); // [RQ13] [RQ22]
		end
		else if (i_rotate_left)
		begin
			regs_nxt[ccrfs_pkg::IDX_ACC] = rot_val; // [RQ12]
			carry_nxt[cur] = regs_r[ccrfs_pkg::IDX_ACC][7]; // [RQ12]
			zero_nxt[cur] = (rot_val == 8'h00); // [RQ13]
		end
		else if (i_bit_test)
			carry_nxt[cur] = i_bit_value; // [RQ12] [RQ11]
		// a bus write in the same cycle overrides the alu result
		if (i_data_wr && wr_dec[3])
			regs_nxt[wr_dec[2:0]] = i_data_wdata; // [RQ1] [RQ2] [RQ3]
		if (i_data_rd && rd_dec[3])
		begin
			rdata_nxt = regs_r[rd_dec[2:0]];
			hit_nxt = 1'b1;
		end
		carry_out_nxt = carry_nxt[pair_of(ctx_nxt)]; // [RQ8]
		zero_out_nxt = zero_nxt[pair_of(ctx_nxt)]; // [RQ8]
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			pc_r <= ccrfs_pkg::RESET_VECTOR; // [RQ21]
			ctx_r <= ccrfs_pkg::CTX_NMI; // [RQ14]
			hist0_r <= ccrfs_pkg::CTX_NORMAL;
			hist1_r <= ccrfs_pkg::CTX_NORMAL;
			carry_r <= 3'h0;
			zero_r <= 3'h0;
			regs_r <= '0;
			rdata_r <= ccrfs_pkg::REG_RESET;
			hit_r <= 1'b0;
			carry_out_r <= 1'b0;
			zero_out_r <= 1'b0;
		end
		else
		begin
			pc_r <= pc_nxt;
			ctx_r <= ctx_nxt;
			hist0_r <= hist0_nxt;
			hist1_r <= hist1_nxt;
			carry_r <= carry_nxt; // [RQ10]
			zero_r <= zero_nxt; // [RQ10]
			regs_r <= regs_nxt;
			rdata_r <= rdata_nxt;
			hit_r <= hit_nxt;
			carry_out_r <= carry_out_nxt;
			zero_out_r <= zero_out_nxt;
		end
	end

	assign o_program_counter = pc_r;
	assign o_context = ctx_r;
	assign o_carry = carry_out_r;
	assign o_zero = zero_out_r;
	assign o_data_rdata = rdata_r;
	assign o_data_hit = hit_r;
	assign o_accumulator = regs_r[ccrfs_pkg::IDX_ACC];

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	logic no_load;
	assign no_load = !(entry || i_call || i_absolute_branch
		|| i_subroutine_return || i_return_from_interrupt);

	sequence s_call;
		i_call && !entry;
	endsequence
	sequence s_ret;
		i_subroutine_return && no_load == 1'b0 && !entry && !i_call && !i_absolute_branch;
	endsequence
	sequence s_irq_from_normal;
		ctx_r == ccrfs_pkg::CTX_NORMAL && i_irq_entry && !i_nmi_entry;
	endsequence
	sequence s_return_from_interrupt;
		i_return_from_interrupt && !entry && !i_call && !i_absolute_branch;
	endsequence

	property p_reset_state;
		$fell(i_reset) |-> pc_r == ccrfs_pkg::RESET_VECTOR && ctx_r == ccrfs_pkg::CTX_NMI
			&& stk.empty;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad state after reset"); // [RQ21]

	property p_fetch;
		(i_fetch && no_load && !i_branch_rel) |=> pc_r == $past(pc_r) + 12'h001;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch did not advance counter"); // [RQ5]

	property p_rel;
		(i_branch_rel && no_load) |=> pc_r == $past(pc_r) + {{4{$past(i_rel_offset[7])}},
			$past(i_rel_offset)};
	endproperty
	a_rel: assert property (p_rel) else $error("relative branch sum wrong"); // [RQ6]

	property p_jump;
		(i_absolute_branch && !entry && !i_call) |=> pc_r == $past(i_target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded"); // [RQ7]

	property p_call_return;
		s_call ##1 s_ret |=> pc_r == $past(pc_r, 2);
	endproperty
	a_call_return: assert property (p_call_return) else $error("return address lost"); // [RQ17]

	property p_empty_return;
		((i_subroutine_return || i_return_from_interrupt) && !entry && !i_call
			&& !i_absolute_branch && stk.empty) |=> pc_r == $past(pc_r);
	endproperty
	a_empty_return: assert property (p_empty_return) else $error("empty return moved pc"); // [RQ19]

	property p_irq_round_trip;
		s_irq_from_normal ##1 s_return_from_interrupt |=> ctx_r == ccrfs_pkg::CTX_NORMAL;
	endproperty
	a_irq_round_trip: assert property (p_irq_round_trip) else $error("context not restored"); // [RQ9]

	property p_switch_keeps_flags;
		(entry && !i_alu_valid && !i_rotate_left && !i_bit_test) |=> $stable(carry_r)
			&& $stable(zero_r);
	endproperty
	a_switch_keeps_flags: assert property (p_switch_keeps_flags) else $error("flags changed"); // [RQ10]

	property p_isolation;
		(i_alu_valid && ctx_r == ccrfs_pkg::CTX_NORMAL) |=> $stable(carry_r[2:1])
			&& $stable(zero_r[2:1]);
	endproperty
	a_isolation: assert property (p_isolation) else $error("foreign flag pair written"); // [RQ11]

	property p_zero;
		(i_alu_valid && !entry && !i_return_from_interrupt) |=> o_zero == ($past(i_alu_result) == 8'h00)
			&& (o_accumulator == $past(i_alu_result) || $past(i_data_wr));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RQ13]

	property p_acc_map;
		(i_data_wr && i_data_addr == ccrfs_pkg::ADDR_ACCUMULATOR) |=> o_accumulator == $past(i_data_wdata);
	endproperty
	a_acc_map: assert property (p_acc_map) else $error("accumulator not at FFh"); // [RQ1]
endmodule
`default_nettype wire

// file: include/ccrfs_pkg.sv
// constants for the core register file, flag pairs and return stack
// assumes one 100 MHz clock and a synchronous active-high reset
`default_nettype none
package ccrfs_pkg;
	localparam int PC_W = 12;
	localparam int DATA_W = 8;
	localparam int STACK_LEVELS = 6;
	localparam int DEPTH_W = 3;
	localparam logic [DEPTH_W-1:0] DEPTH_MAX = 3'h6;
	localparam logic [PC_W-1:0] RESET_VECTOR = 12'hFFE;
	localparam logic [PC_W-1:0] STACK_RESET = 12'h000;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	// data-space byte addresses
	localparam logic [7:0] ADDR_PTR_FIRST = 8'h80;
	localparam logic [7:0] ADDR_PTR_SECOND = 8'h81;
	localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
	localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
	localparam logic [7:0] ADDR_ACCUMULATOR = 8'hFF;
	// storage index of each data-space register
	localparam int NUM_REGS = 5;
	localparam logic [2:0] IDX_PTR_FIRST = 3'h0;
	localparam logic [2:0] IDX_PTR_SECOND = 3'h1;
	localparam logic [2:0] IDX_SHORT_FIRST = 3'h2;
	localparam logic [2:0] IDX_SHORT_SECOND = 3'h3;
	localparam logic [2:0] IDX_ACC = 3'h4;
	// index of each flag pair
	localparam logic [1:0] PAIR_NORMAL = 2'h0;
	localparam logic [1:0] PAIR_IRQ = 2'h1;
	localparam logic [1:0] PAIR_NMI = 2'h2;
	typedef enum logic [2:0] {
		CTX_NORMAL = 3'b001,
		CTX_IRQ = 3'b010,
		CTX_NMI = 3'b100
	} ccrfs_ctx_type;
endpackage
`default_nettype wire

// file: include/ccrfs_stack_if.sv
// link between the core control and its hardware return stack
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ccrfs_stack_if;
	logic push;
	logic pop;
	logic [11:0] push_data;
	logic [11:0] top;
	logic empty;
	logic [2:0] depth;
	modport core(output push, output pop, output push_data, input top, input empty, input depth);
	modport store(input push, input pop, input push_data, output top, output empty, output depth);
endinterface
`default_nettype wire

// file: hdl/ccrfs_stack.sv
// six-level return stack with saturating depth
// assumes push and pop are never asserted together; push wins if they are
`timescale 1ns/1ps
`default_nettype none
module ccrfs_stack
(
	input wire logic i_clk,
	input wire logic i_reset,
	ccrfs_stack_if.store st
);
	logic [ccrfs_pkg::STACK_LEVELS-1:0][ccrfs_pkg::PC_W-1:0] levels_r;
	logic [ccrfs_pkg::STACK_LEVELS-1:0][ccrfs_pkg::PC_W-1:0] levels_nxt;
	logic [ccrfs_pkg::DEPTH_W-1:0] depth_r;
	logic [ccrfs_pkg::DEPTH_W-1:0] depth_nxt;

	always_comb
	begin
		levels_nxt = levels_r;
		depth_nxt = depth_r;
		if (st.push)
		begin
			// oldest level falls off the bottom, no fault raised
			levels_nxt = {levels_r[ccrfs_pkg::STACK_LEVELS-2:0], st.push_data}; // [RQ16]
			if (depth_r != ccrfs_pkg::DEPTH_MAX)
				depth_nxt = depth_r + 3'h1; // [RQ18]
		end
		else if (st.pop)
		begin
			levels_nxt = {ccrfs_pkg::STACK_RESET, levels_r[ccrfs_pkg::STACK_LEVELS-1:1]}; // [RQ17]
			if (depth_r != 3'h0)
				depth_nxt = depth_r - 3'h1; // [RQ19]
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			levels_r <= '0; // [RQ21]
			depth_r <= 3'h0;
		end
		else
		begin
			levels_r <= levels_nxt; // [RQ15]
			depth_r <= depth_nxt;
		end
	end

	assign st.top = levels_r[0];
	assign st.empty = (depth_r == 3'h0);
	assign st.depth = depth_r;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	property p_depth_saturates;
		(st.push && depth_r == 3'h6) |=> depth_r == 3'h6 && levels_r[0] == $past(st.push_data);
	endproperty
	a_depth_saturates: assert property (p_depth_saturates) else $error("stack depth left six"); // [RQ18]

	property p_push_shifts;
		st.push |=> levels_r[1] == $past(levels_r[0]) && levels_r[5] == $past(levels_r[4]);
	endproperty
	a_push_shifts: assert property (p_push_shifts) else $error("push did not shift levels"); // [RQ16]
endmodule
`default_nettype wire

// file: test/ccrfs_prog_model.sv
// program space model: returns a word of program memory for any address
// assumes the core reads jump, call and vector operands combinationally
`timescale 1ns/1ps
`default_nettype none
module ccrfs_prog_model
(
	input wire logic [11:0] i_addr,
	output logic [11:0] o_word
);
	// a scrambled pattern keeps every target distinct from its own address
	assign o_word = {i_addr[3:0], i_addr[11:4]} ^ 12'hA5C;
endmodule
`default_nettype wire

// file: test/tb_cpu_core_register_flag_stack.sv
// self-checking bench for the core register file, flag pairs and return stack
// assumes the program space model feeds operand words at the current counter
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core_register_flag_stack;
	typedef struct {int sel; logic [11:0] exp;} ccrfs_note_type;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_data_addr, i_data_wdata, i_rel_offset, i_alu_result;
	logic i_data_rd, i_data_wr, i_fetch, i_branch_rel, i_absolute_branch, i_call;
	logic i_irq_entry, i_nmi_entry, i_subroutine_return, i_return_from_interrupt;
	logic i_alu_valid, i_alu_carry_en, i_alu_carry, i_rotate_left, i_bit_test, i_bit_value;
	logic [12:0] drv;
	logic [11:0] word, o_program_counter, pc_m, got;
	logic [7:0] o_data_rdata, o_accumulator;
	logic [7:0] d[6];
	logic [7:0] adr[6];
	logic o_data_hit, o_carry, o_zero;
	logic [2:0] o_context;
	logic [11:0] stk[$];
	ccrfs_note_type notes[$];
	ccrfs_note_type nt;
	int n_mismatch = 0;
	int n_compared = 0;
	string names[5] = '{"read", "pc", "acc", "flags", "context"};
	always #5 i_clk = ~i_clk;
	ccrfs_prog_model i_mem (.i_addr(o_program_counter), .o_word(word));
	ccrfs_core i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_data_addr(i_data_addr),
		.i_data_rd(drv[12]), .i_data_wr(drv[11]), .i_data_wdata(i_data_wdata),
		.i_fetch(drv[10]), .i_branch_rel(drv[9]), .i_rel_offset(i_rel_offset),
		.i_absolute_branch(drv[8]), .i_call(drv[7]), .i_target(word),
		.i_irq_entry(drv[6]), .i_nmi_entry(drv[5]), .i_vector(word),
		.i_subroutine_return(drv[4]),
		.i_return_from_interrupt(drv[3]), .i_alu_valid(drv[2]),
		.i_alu_carry_en(i_alu_carry_en), .i_alu_result(i_alu_result),
		.i_alu_carry(i_alu_carry), .i_rotate_left(drv[1]), .i_bit_test(drv[0]),
		.i_bit_value(i_bit_value), .o_data_rdata(o_data_rdata), .o_data_hit(o_data_hit),
		.o_program_counter(o_program_counter), .o_accumulator(o_accumulator),
		.o_carry(o_carry), .o_zero(o_zero), .o_context(o_context));
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// callers stage strobes; the pins change once per edge, so no strobe glitches
	task automatic tick();
		drv = {i_data_rd, i_data_wr, i_fetch, i_branch_rel, i_absolute_branch, i_call,
			i_irq_entry, i_nmi_entry, i_subroutine_return, i_return_from_interrupt,
			i_alu_valid, i_rotate_left, i_bit_test};
		{i_data_rd, i_data_wr, i_fetch, i_branch_rel, i_absolute_branch, i_call, i_irq_entry,
			i_nmi_entry, i_subroutine_return, i_return_from_interrupt, i_alu_valid,
			i_rotate_left, i_bit_test} = 13'h0000;
		@(posedge i_clk);
		#1;
	endtask
	task automatic note(input int sel, input logic [11:0] exp);
		notes.push_back('{sel, exp});
	endtask
	task automatic push_to(input logic [11:0] t);
		stk.push_front(pc_m);
		if (stk.size() > 6)
			void'(stk.pop_back());
		pc_m = t;
	endtask
	task automatic pop_pc();
		if (stk.size() > 0)
			pc_m = stk.pop_front();
	endtask
	// notes are settled half a cycle after the edge that produced them
	always @(negedge i_clk)
	begin
		while (notes.size() > 0)
		begin
			nt = notes.pop_front();
			case (nt.sel)
				0: got = {3'h0, o_data_hit, o_data_rdata};
				1: got = o_program_counter;
				2: got = {4'h0, o_accumulator};
				3: got = {10'h000, o_carry, o_zero};
				default: got = {9'h000, o_context};
			endcase
			n_compared++;
			if (got !== nt.exp)
			begin
				n_mismatch++;
				$display("unexpected %s expected %h seen %h", names[nt.sel], nt.exp, got);
			end
		end
	end
	initial
	begin
		repeat (5000) @(posedge i_clk);
		n_mismatch++;
		close_out();
	end
	initial
	begin
		i_data_addr = 8'h00;
		i_data_wdata = 8'h00;
		i_rel_offset = 8'h00;
		i_alu_result = 8'h00;
		{i_alu_carry_en, i_alu_carry, i_bit_value} = 3'h0;
		{i_data_rd, i_data_wr, i_fetch, i_branch_rel, i_absolute_branch, i_call, i_irq_entry,
			i_nmi_entry, i_subroutine_return, i_return_from_interrupt, i_alu_valid,
			i_rotate_left, i_bit_test} = 13'h0000;
		drv = 13'h0000;
		d[0] = $urandom(9439);
		adr = '{ccrfs_pkg::ADDR_PTR_FIRST, ccrfs_pkg::ADDR_PTR_SECOND,
			ccrfs_pkg::ADDR_SHORT_FIRST, ccrfs_pkg::ADDR_SHORT_SECOND,
			ccrfs_pkg::ADDR_ACCUMULATOR, 8'h84};
		repeat (6) @(posedge i_clk);
		#1;
		i_reset = 1'b0;
		pc_m = 12'hFFE;
		note(1, 12'hFFE);
		note(4, 12'h004);
		note(3, 12'h000);
		for (int k = 0; k < 6; k++)
		begin
			d[k] = $urandom();
			i_data_wr = 1'b1;
			i_data_addr = adr[k];
			i_data_wdata = d[k];
			tick();
		end
		// back-to-back reads; the unmapped byte must come back empty
		for (int k = 0; k < 6; k++)
		begin
			i_data_rd = 1'b1;
			i_data_addr = adr[k];
			tick();
			note(0, (k == 5) ? 12'h000 : {4'h1, d[k]});
		end
		i_data_rd = 1'b1;
		i_data_wr = 1'b1;
		i_data_addr = adr[0];
		i_data_wdata = ~d[0];
		tick();
		note(0, {4'h1, d[0]});
		i_data_rd = 1'b1;
		tick();
		note(0, {4'h1, ~d[0]});
		// the counter wraps at twelve bits
		repeat (2)
		begin
			i_fetch = 1'b1;
			tick();
			pc_m = pc_m + 12'h001;
			note(1, pc_m);
		end
		for (int k = 0; k < 2; k++)
		begin
			i_branch_rel = 1'b1;
			i_rel_offset = (k == 0) ? 8'hF6 : 8'h07;
			tick();
			pc_m = pc_m + {{4{i_rel_offset[7]}}, i_rel_offset};
			note(1, pc_m);
		end
		i_absolute_branch = 1'b1;
		tick();
		pc_m = {pc_m[3:0], pc_m[11:4]} ^ 12'hA5C;
		note(1, pc_m);
		// seven nested calls overflow six levels, eight returns underflow
		repeat (7)
		begin
			i_call = 1'b1;
			tick();
			push_to({pc_m[3:0], pc_m[11:4]} ^ 12'hA5C);
			note(1, pc_m);
		end
		repeat (8)
		begin
			i_subroutine_return = 1'b1;
			tick();
			pop_pc();
			note(1, pc_m);
		end
		note(2, {4'h0, d[4]});
		i_alu_valid = 1'b1;
		i_alu_carry_en = 1'b1;
		i_alu_result = 8'h00;
		i_alu_carry = 1'b1;
		tick();
		note(2, 12'h000);
		note(3, 12'h003);
		i_return_from_interrupt = 1'b1;
		tick();
		note(4, 12'h001);
		note(3, 12'h000);
		note(1, pc_m);
		i_alu_valid = 1'b1;
		i_alu_result = 8'h80;
		tick();
		note(3, 12'h002);
		i_rotate_left = 1'b1;
		tick();
		note(2, 12'h001);
		note(3, 12'h002);
		i_rotate_left = 1'b1;
		tick();
		note(2, 12'h003);
		note(3, 12'h000);
		i_irq_entry = 1'b1;
		tick();
		push_to({pc_m[3:0], pc_m[11:4]} ^ 12'hA5C);
		note(1, pc_m);
		note(4, 12'h002);
		note(3, 12'h000);
		i_bit_test = 1'b1;
		i_bit_value = 1'b1;
		tick();
		note(3, 12'h002);
		i_alu_valid = 1'b1;
		i_alu_carry_en = 1'b0;
		i_alu_result = 8'h00;
		tick();
		note(3, 12'h003);
		i_nmi_entry = 1'b1;
		tick();
		push_to({pc_m[3:0], pc_m[11:4]} ^ 12'hA5C);
		note(4, 12'h004);
		note(3, 12'h003);
		for (int k = 0; k < 2; k++)
		begin
			i_return_from_interrupt = 1'b1;
			tick();
			pop_pc();
			note(1, pc_m);
			note(4, (k == 0) ? 12'h002 : 12'h001);
			note(3, (k == 0) ? 12'h003 : 12'h000);
		end
		// interrupt straight back out, then a bus write racing the alu
		i_irq_entry = 1'b1;
		tick();
		push_to({pc_m[3:0], pc_m[11:4]} ^ 12'hA5C);
		note(1, pc_m);
		note(4, 12'h002);
		i_return_from_interrupt = 1'b1;
		tick();
		pop_pc();
		note(1, pc_m);
		note(4, 12'h001);
		i_alu_valid = 1'b1;
		i_data_wr = 1'b1;
		i_data_addr = ccrfs_pkg::ADDR_ACCUMULATOR;
		i_data_wdata = d[1];
		tick();
		note(2, {4'h0, d[1]});
		note(3, 12'h001);
		tick();
		repeat (2) @(posedge i_clk);
		close_out();
	end
endmodule
`default_nettype wire
